/* File: card_pwr_pkg.sv */
/*
 * Shared types and constants for the serial card power switch control.
 * Assumes a 32-bit APB master and a single pclk domain.
 */
package card_pwr_pkg;

	// Control word as shifted in, bit ten first
	typedef struct packed {
		logic spare_bit;             // Bit 10, stored only
		logic prog_low_volt_sel_bit; // Bit 9
		logic outputs_on_bit;        // Bit 8
		logic [3:0] unused_bits;     // Bits 7..4
		logic main_sel_hi_bit;       // Bit 3
		logic main_sel_lo_bit;       // Bit 2
		logic prog_sel_lo_bit;       // Bit 1
		logic prog_sel_hi_bit;       // Bit 0
	} ctl_word_t;

	localparam int WORD_W = 11;
	localparam ctl_word_t WORD_RESET = 11'h000;

	// Level driven onto a supply output
	typedef enum logic [2:0] {
		SUP_GND = 3'h0,
		SUP_3V3 = 3'h1,
		SUP_5V = 3'h3,
		SUP_12V = 3'h2,
		SUP_HIZ = 3'h6
	} supply_t;

	// Supply switch commands toward the analog side
	typedef struct packed {
		supply_t main_level;  // Main supply output level
		supply_t prog_level;  // Programming supply output level
		logic [3:0] gnd_sw;   // gnd_switch_four..gnd_switch_one closed
		logic limit_main;     // Current limit active on main output
		logic limit_prog;     // Current limit active on prog output
	} card_out_t;

	localparam card_out_t CARD_OUT_RESET = '{SUP_GND, SUP_GND, 4'hf, 1'b0, 1'b0};

	// Pins from outside the pclk domain
	typedef struct packed {
		logic ser_clk;
		logic ser_data;
		logic ser_load;
		logic card_reset_n;
		logic power_off_n;
		logic oc_main;
		logic oc_prog;
		logic over_temp;
		logic temp_cool;
		logic fault_pin_n;
	} pins_t;

	// Pulled-up pins idle high
	localparam pins_t PINS_IDLE = 10'h061;

	// Register byte offsets
	localparam logic [11:0] OFF_CTRL = 12'h000;
	localparam logic [11:0] OFF_STATUS = 12'h004;
	localparam logic [11:0] OFF_WORD = 12'h008;
	localparam logic [11:0] OFF_SHIFT = 12'h00c;
	localparam logic [11:0] OFF_IRQ_STAT = 12'h010;
	localparam logic [11:0] OFF_IRQ_MASK = 12'h014;

	// Control register fields and reset value
	localparam int CTRL_LOAD_EN = 0;
	localparam int CTRL_FORCE_OFF = 1;
	localparam logic [1:0] CTRL_RESET = 2'h1;

	// Interrupt bits
	localparam int IRQ_W = 3;
	localparam int IRQ_LOAD = 0;
	localparam int IRQ_OVERCUR = 1;
	localparam int IRQ_THERMAL = 2;
	localparam logic [IRQ_W-1:0] IRQ_RESET = 3'h0;

endpackage

/* File: card_pwr_ctrl.sv */
/*
 * Control logic of a single-slot card power switch: serial word intake,
 * output level decode, card reset, shutdown, fault flag, APB registers
 * and a masked interrupt.
 * Assumes all pins are asynchronous to pclk and the serial clock is
 * much slower than pclk (several pclk cycles per level).
 */
`timescale 1ns/1ns
`default_nettype none

// Behaviour
// - Data sampled on serial clock rising edge
// - Load strobe rise moves 11-bit word active
// - Shutdown pin or bit eight low forces Hi-Z
// - Card reset closes only ground switches
// - Stay grounded until released and new load
// - Loads ignored while card reset asserted
// - Overcurrent limits only the affected output
// - Overcurrent drives fault flag low
// - Overtemperature shuts outputs until cooled
// - Overtemperature also drives fault flag low
// - Main select bits decode 0, 3.3, 5 V
// - Programming bits decode 0/3.3/5/12 V/Hi-Z
// - Reset and shutdown active low, pulled up
module card_pwr_ctrl #(
	parameter int ADDR_W = 12
) (
	input wire logic pclk,                   // System clock
	input wire logic presetn,                // Async reset, active low
	input wire logic clk_en,                 // Freezes all state when low
	input wire logic psel,                   // APB select
	input wire logic penable,                // APB enable
	input wire logic pwrite,                 // APB write
	input wire logic [ADDR_W-1:0] paddr,     // APB byte address
	input wire logic [31:0] pwdata,          // APB write data
	output logic [31:0] prdata,              // APB read data
	output logic pready,                     // APB ready
	output logic pslverr,                    // APB error, unmapped address
	input wire logic ser_clk,                // Serial clock pin
	input wire logic ser_data,               // Serial data pin
	input wire logic ser_load,               // Load strobe pin
	input wire logic card_reset_n,           // Card reset pin, active low
	input wire logic power_off_n,            // Shutdown pin, active low
	input wire logic oc_main,                // Main output overcurrent sense
	input wire logic oc_prog,                // Prog output overcurrent sense
	input wire logic over_temp,              // Die above shutdown limit
	input wire logic temp_cool,              // Die below hysteresis limit
	output card_pwr_pkg::card_out_t card_out, // Supply switch commands
	input wire logic fault_flag_n_i,         // Fault flag pin level
	output logic fault_flag_n_o,             // Fault flag drive value
	output logic fault_flag_n_oe,            // Fault flag pulls low
	output logic irq                         // Interrupt, active high
);
	import card_pwr_pkg::*;

	// Decode of the main select pair
	function automatic supply_t decode_main(input ctl_word_t w);
		unique case ({w.main_sel_hi_bit, w.main_sel_lo_bit})
			2'b01: decode_main = SUP_3V3;
			2'b10: decode_main = SUP_5V;
			default: decode_main = SUP_GND;
		endcase
	endfunction

	// Decode of the programming select pair
	function automatic supply_t decode_prog(input ctl_word_t w);
		unique case ({w.prog_sel_hi_bit, w.prog_sel_lo_bit})
			2'b00: decode_prog = SUP_GND;
			2'b01: decode_prog = w.prog_low_volt_sel_bit ? SUP_5V : SUP_3V3;
			2'b10: decode_prog = SUP_12V;
			default: decode_prog = SUP_HIZ;
		endcase
	endfunction

	pins_t pins_raw;
	pins_t sync_a;
	pins_t pins_s;
	pins_t pins_d;
	logic [WORD_W-1:0] shift;
	ctl_word_t active;
	logic grounded;
	logic thermal_off;
	logic [1:0] ctrl;
	logic [IRQ_W-1:0] irq_stat;
	logic [IRQ_W-1:0] irq_mask;

	// Pin bundle
	assign pins_raw = '{ser_clk, ser_data, ser_load, card_reset_n, power_off_n,
		oc_main, oc_prog, over_temp, temp_cool, fault_flag_n_i};

	// Two-stage synchronisers, pulled-up pins idle high
	genvar gi;
	generate
		for (gi = 0; gi < $bits(pins_t); gi++) begin : g_sync
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					sync_a[gi] <= PINS_IDLE[gi];
					pins_s[gi] <= PINS_IDLE[gi];
					pins_d[gi] <= PINS_IDLE[gi];
				end else if (clk_en) begin
					sync_a[gi] <= pins_raw[gi];
					pins_s[gi] <= sync_a[gi];
					pins_d[gi] <= pins_s[gi];
				end
			end
		end
	endgenerate

	// Edge detection on synchronised pins
	wire clk_rise = pins_s.ser_clk & ~pins_d.ser_clk;
	wire load_rise = pins_s.ser_load & ~pins_d.ser_load;
	wire card_rst = ~pins_s.card_reset_n;
	wire load_ok = load_rise & ~card_rst & ctrl[CTRL_LOAD_EN];
	wire oc_any = pins_s.oc_main | pins_s.oc_prog;
	wire oc_rise = oc_any & ~(pins_d.oc_main | pins_d.oc_prog);

	// Serial intake, first bit ends up in bit ten
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			shift <= '0;
		end else if (clk_en && clk_rise) begin
			shift <= {shift[WORD_W-2:0], pins_s.ser_data};
		end
	end

	// Word transfer on load strobe
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			active <= WORD_RESET;
		end else if (clk_en && load_ok) begin
			active <= ctl_word_t'(shift);
		end
	end

	// Grounded state held from card reset to the next accepted load
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			grounded <= 1'b1;
		end else if (clk_en) begin
			grounded <= card_rst | (grounded & ~load_ok);
		end
	end

	// Thermal shutdown with hysteresis
	wire next_thermal_off = pins_s.over_temp | (thermal_off & ~pins_s.temp_cool);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			thermal_off <= 1'b0;
		end else if (clk_en) begin
			thermal_off <= next_thermal_off;
		end
	end

	// Output level selection
	wire hiz_force = ~pins_s.power_off_n | ~active.outputs_on_bit | thermal_off
		| ctrl[CTRL_FORCE_OFF];
	wire supply_t next_main = grounded ? SUP_GND : hiz_force ? SUP_HIZ
		: decode_main(active);
	wire supply_t next_prog = grounded ? SUP_GND : hiz_force ? SUP_HIZ
		: decode_prog(active);
	wire card_out_t next_card_out = '{next_main, next_prog, {4{grounded}},
		pins_s.oc_main, pins_s.oc_prog};
	wire next_fault = oc_any | thermal_off;

	// Registered outputs toward the switches and the fault pin
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			card_out <= CARD_OUT_RESET;
			fault_flag_n_oe <= 1'b0;
		end else if (clk_en) begin
			card_out <= next_card_out;
			fault_flag_n_oe <= next_fault;
		end
	end
	assign fault_flag_n_o = 1'b0;

	// APB decode
	wire [11:0] addr = 12'(paddr);
	wire access = psel & penable & ~pready;
	wire hit_ctrl = addr == OFF_CTRL;
	wire hit_stat = addr == OFF_STATUS;
	wire hit_word = addr == OFF_WORD;
	wire hit_shift = addr == OFF_SHIFT;
	wire hit_istat = addr == OFF_IRQ_STAT;
	wire hit_imask = addr == OFF_IRQ_MASK;
	wire mapped = hit_ctrl | hit_stat | hit_word | hit_shift | hit_istat | hit_imask;
	wire wr = access & pwrite & mapped;
	wire [31:0] status_word = {22'h0, pins_s.fault_pin_n, next_fault, thermal_off,
		grounded, card_out.prog_level, card_out.main_level};
	wire [31:0] next_rdata = hit_ctrl ? {30'h0, ctrl}
		: hit_stat ? status_word
		: hit_word ? {21'h0, active}
		: hit_shift ? {21'h0, shift}
		: hit_istat ? {29'h0, irq_stat}
		: hit_imask ? {29'h0, irq_mask} : 32'h0;

	// APB answer, one wait state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
		end else if (clk_en) begin
			pready <= access;
			pslverr <= access & ~mapped;
			prdata <= (access & ~pwrite) ? next_rdata : 32'h0;
		end
	end

	// Control and mask registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= CTRL_RESET;
			irq_mask <= IRQ_RESET;
		end else if (clk_en && wr) begin
			if (hit_ctrl) ctrl <= pwdata[1:0];
			if (hit_imask) irq_mask <= pwdata[IRQ_W-1:0];
		end
	end

	// Sticky events, a new event wins over a clear
	wire [IRQ_W-1:0] events = {next_thermal_off & ~thermal_off, oc_rise, load_ok};
	wire [IRQ_W-1:0] clr = (wr && hit_istat) ? pwdata[IRQ_W-1:0] : '0;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat <= IRQ_RESET;
			irq <= 1'b0;
		end else if (clk_en) begin
			irq_stat <= (irq_stat & ~clr) | events;
			irq <= |(((irq_stat & ~clr) | events) & irq_mask);
		end
	end

	// Checks of the block behaviour
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_shift_sample: assert property (
		clk_en && clk_rise |=> shift == {$past(shift[WORD_W-2:0]), $past(pins_s.ser_data)})
		else $error("shift register did not take the serial bit");

	a_word_load: assert property (
		clk_en && load_ok |=> active == $past(shift) && irq_stat[IRQ_LOAD])
		else $error("load strobe did not transfer the word");

	a_reset_no_load: assert property (
		clk_en && card_rst && load_rise |=> $stable(active) && grounded)
		else $error("word changed during card reset");

	a_reset_ground: assert property (
		clk_en && card_rst ##1 clk_en |=> card_out.gnd_sw == 4'hf
			&& card_out.main_level == SUP_GND && card_out.prog_level == SUP_GND)
		else $error("card reset did not ground both outputs");

	a_ground_hold: assert property (
		clk_en && grounded && !load_ok |=> grounded)
		else $error("grounded state left without a load");

	a_shutdown_hiz: assert property (
		clk_en && !grounded && hiz_force |=> card_out.main_level == SUP_HIZ
			&& card_out.prog_level == SUP_HIZ && card_out.gnd_sw == 4'h0)
		else $error("shutdown did not float the outputs");

	a_main_decode: assert property (
		clk_en && !grounded && !hiz_force |=> card_out.main_level == decode_main($past(active)))
		else $error("main supply decode wrong");

	a_prog_decode: assert property (
		clk_en && !grounded && !hiz_force |=> card_out.prog_level == decode_prog($past(active)))
		else $error("programming supply decode wrong");

	a_limit_split: assert property (
		clk_en && pins_s.oc_main && !pins_s.oc_prog |=> card_out.limit_main
			&& !card_out.limit_prog)
		else $error("current limit reached the wrong output");

	a_fault_flag: assert property (
		clk_en && (oc_any || thermal_off) |=> fault_flag_n_oe && !fault_flag_n_o)
		else $error("fault flag not pulled low");

	a_fault_release: assert property (
		clk_en && !oc_any && !thermal_off |=> !fault_flag_n_oe)
		else $error("fault flag held after conditions cleared");

	a_thermal_hold: assert property (
		clk_en && thermal_off && !pins_s.temp_cool |=> thermal_off)
		else $error("thermal shutdown released before cooling");

	// Main scenarios reached
	c_word_loaded: cover property (clk_en && load_ok && !grounded);
	c_thermal_trip: cover property (clk_en && events[IRQ_THERMAL]);
	c_irq_raised: cover property (!irq ##1 irq);
	c_unmapped: cover property (pready && pslverr);

endmodule
`default_nettype wire

/* File: card_pwr_host.sv */
/* Serial host model that shifts control words into the card power control.
   Assumes the bench calls send with an 11-bit word; link period 48 ns. */
`timescale 1ns/1ns
`default_nettype none
module card_pwr_host (
	output var logic ser_clk, // Serial clock, still between frames
	output var logic ser_data, // Serial data
	output var logic ser_load // Load strobe, pulled down
);
	// Idle levels before the first frame
	initial begin
		ser_clk = 1'b0;
		ser_data = 1'b0;
		ser_load = 1'b0;
	end
	// One frame: bit ten first, data stable across each rise, then the strobe
	task automatic send(input logic [10:0] w);
		for (int i = 10; i >= 0; i--) begin
			ser_data = w[i];
			#24 ser_clk = 1'b1;
			#24 ser_clk = 1'b0;
		end
		ser_data = ~ser_data; // Released line shows no stale bit
		ser_load = 1'b1;
		#48 ser_load = 1'b0;
		#48;
	endtask
endmodule
`default_nettype wire

/* File: card_pwr_ctrl_tb.sv */
/* Self-checking bench for the card power control, APB reads scored from a queue.
   Assumes the host model drives the serial pins and pclk runs at 250 MHz. */
`timescale 1ns/1ns
`default_nettype none
module card_pwr_ctrl_tb;
	import card_pwr_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, clk_en;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic card_reset_n, power_off_n, oc_main, oc_prog, over_temp, temp_cool;
	logic fault_o, fault_oe;
	wire logic ser_clk, ser_data, ser_load, fault_pin;
	card_out_t card_out;
	ctl_word_t w;
	int err_total = 0;
	int n_compared = 0;
	logic [45:0] notes[$];
	logic [45:0] nt;
	logic [15:0] lfsr = 16'h0060;

	// Open-drain fault pin with pull-up
	assign fault_pin = fault_oe ? fault_o : 1'b1;

	card_pwr_ctrl dut_u (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .ser_clk(ser_clk), .ser_data(ser_data),
		.ser_load(ser_load), .card_reset_n(card_reset_n), .power_off_n(power_off_n),
		.oc_main(oc_main), .oc_prog(oc_prog), .over_temp(over_temp), .temp_cool(temp_cool),
		.card_out(card_out), .fault_flag_n_i(fault_pin), .fault_flag_n_o(fault_o),
		.fault_flag_n_oe(fault_oe), .irq(irq));
	card_pwr_host host_u (.ser_clk(ser_clk), .ser_data(ser_data), .ser_load(ser_load));

	// System clock
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic tally_and_finish();
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// One APB transfer; the expected answer goes on the queue first
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic e);
		int n;
		n = 0;
		notes.push_back({wr, a, e, d});
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 50) begin
			@(posedge pclk);
			n++;
		end
		if (n == 50) begin
			err_total++;
			tally_and_finish();
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Scoreboard: each completed transfer takes the oldest note
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1) begin
			nt = notes.pop_front();
			check("pslverr", 32'(pslverr), 32'(nt[32]));
			if (!nt[45])
				check("prdata", prdata, nt[31:0]);
		end
	end

	task automatic settle();
		repeat (8) @(posedge pclk);
	endtask

	task automatic load(input logic [10:0] v);
		host_u.send(v);
		settle();
	endtask

	function automatic supply_t dm(input logic [1:0] b);
		case (b)
			2'h1: return SUP_3V3;
			2'h2: return SUP_5V;
			default: return SUP_GND;
		endcase
	endfunction

	function automatic supply_t dp(input logic hi, input logic lo, input logic v9);
		case ({hi, lo})
			2'h0: return SUP_GND;
			2'h1: return v9 ? SUP_5V : SUP_3V3;
			2'h2: return SUP_12V;
			default: return SUP_HIZ;
		endcase
	endfunction

	// Status word: pin, fault, thermal, grounded, prog level, main level
	function automatic logic [31:0] st(input supply_t m, input supply_t p);
		return {22'h000000, 4'h8, p, m};
	endfunction

	// Hang guard
	initial begin
		repeat (100000) @(posedge pclk);
		err_total++;
		tally_and_finish();
	end

	// Main sequence
	initial begin
		presetn = 1'b0;
		clk_en = 1'b1;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{card_reset_n, power_off_n, oc_main, oc_prog, over_temp, temp_cool} = 6'h30;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		check("card_out", 32'(card_out), 32'(CARD_OUT_RESET));
		apb(0, OFF_STATUS, 32'h240, 0);
		apb(0, OFF_CTRL, 32'h1, 0);
		card_reset_n <= 1'b0;
		load(11'h104);
		apb(0, OFF_STATUS, 32'h240, 0);
		apb(0, OFF_WORD, 32'h0, 0);
		card_reset_n <= 1'b1;
		settle();
		apb(0, OFF_STATUS, 32'h240, 0);
		apb(1, OFF_IRQ_MASK, 32'h1, 0);
		for (int i = 0; i < 16; i++) begin
			lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
			w = ctl_word_t'(lfsr[10:0]);
			w.outputs_on_bit = 1'b1;
			{w.prog_low_volt_sel_bit, w.main_sel_hi_bit, w.main_sel_lo_bit} = {i[3], i[3:2]};
			{w.prog_sel_hi_bit, w.prog_sel_lo_bit} = i[1:0];
			load(w);
			apb(0, OFF_WORD, 32'(w), 0);
			apb(0, OFF_STATUS, st(dm(i[3:2]), dp(i[1], i[0], i[3])), 0);
			if (i == 0) begin
				check("irq", 32'(irq), 32'h1);
				apb(1, OFF_IRQ_STAT, 32'h1, 0);
				apb(0, OFF_IRQ_STAT, 32'h0, 0);
				check("irq", 32'(irq), 32'h0);
			end
		end
		apb(1, OFF_IRQ_MASK, 32'h0, 0);
		load(11'h009);
		apb(0, OFF_STATUS, 32'h236, 0);
		load(11'h109);
		power_off_n <= 1'b0;
		settle();
		apb(0, OFF_STATUS, 32'h236, 0);
		power_off_n <= 1'b1;
		settle();
		apb(0, OFF_STATUS, 32'h213, 0);
		for (int k = 0; k < 2; k++) begin
			{oc_main, oc_prog} <= (k == 0) ? 2'h2 : 2'h1;
			settle();
			check("limits", 32'({card_out.limit_main, card_out.limit_prog}), 32'(2 - k));
			check("fault_oe", 32'(fault_oe), 32'h1);
			apb(0, OFF_STATUS, 32'h113, 0);
			{oc_main, oc_prog} <= 2'h0;
			settle();
			check("fault_oe", 32'(fault_oe), 32'h0);
		end
		over_temp <= 1'b1;
		settle();
		apb(0, OFF_STATUS, 32'h1b6, 0);
		over_temp <= 1'b0;
		settle();
		apb(0, OFF_STATUS, 32'h1b6, 0);
		temp_cool <= 1'b1;
		settle();
		apb(0, OFF_STATUS, 32'h213, 0);
		temp_cool <= 1'b0;
		apb(0, 12'h020, 32'h0, 1);
		apb(1, OFF_WORD, 32'h7ff, 0);
		apb(0, OFF_WORD, 32'h109, 0);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		check("card_out", 32'(card_out), 32'(CARD_OUT_RESET));
		presetn <= 1'b1;
		settle();
		apb(0, OFF_STATUS, 32'h240, 0);
		// Clock enable low freezes the outputs against a shutdown
		load(11'h109);
		clk_en <= 1'b0;
		power_off_n <= 1'b0;
		settle();
		check("frozen", 32'(card_out.main_level), 32'(SUP_5V));
		clk_en <= 1'b1;
		settle();
		check("thawed", 32'(card_out.main_level), 32'(SUP_HIZ));
		power_off_n <= 1'b1;
		repeat (4) @(posedge pclk);
		tally_and_finish();
	end
endmodule
`default_nettype wire
